// file: dv/tb_tipg_top.sv
// self-checking bench for the tacho and index generator
// assumes the checker binds itself to tipg_top
`timescale 1ns/1ns
module tb_tipg_top;
  logic ref_clk = 0;
  logic reset_n = 0;
  logic pick = 0;
  tipg_pkg::tipg_comm_t comm = 7'h04;
  logic idx, tacho, comb, ipulse, stall, busy, serr;
  int fall_cnt, k;
  int fail_count = 0;
  int n_checks = 0;
  int cyc = 0;
  // rows: falling, state, tacho expected
  logic [4:0] rows [6] = '{5'h14, 5'h07, 5'h1A, 5'h03, 5'h18, 5'h0D};
  // misses: age count high nibble, state low
  logic [7:0] miss [3] = '{8'h12, 8'h92, 8'h33};
  // short watchdog figure stands in for the integrator's chosen interval
  tipg_top #(.INDEX_CYC(8), .DELAY_CYC(3), .WDOG_CYC(20)) uut (
    .ref_clk(ref_clk), .reset_n(reset_n), .comm_in(comm),
    .index_sense_in(idx), .tacho_out(tacho), .combined_speed_out(comb),
    .index_pulse(ipulse), .stall_pulse(stall), .timing_busy(busy),
    .state_error(serr));
  tipg_host_model host (.ref_clk(ref_clk), .reset_n(reset_n),
    .combined_speed_out(comb), .pick(pick), .fall_cnt(fall_cnt),
    .index_sense_in(idx));
  initial forever #2 ref_clk = ~ref_clk;
  task chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      fail_count++;
      $display("unexpected at %0t seen %h want %h", $time, s, e);
    end
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // one crossing pulse, result settled after its edge
  task zc(input logic f, input logic [2:0] st);
    @(posedge ref_clk) {comm.zc_pulse, comm.zc_falling, comm.comm_state}
      <= {1'b1, f, st};
    @(posedge ref_clk) comm.zc_pulse <= 1'b0;
    #1;
  endtask
  task starts(input int n);
    repeat (n) begin
      @(posedge ref_clk) comm.comm_start <= 1'b1;
      @(posedge ref_clk) comm.comm_start <= 1'b0;
    end
  endtask
  // sensor rise, then time for the synchroniser
  task rise;
    @(posedge ref_clk) pick <= 1'b1;
    @(posedge ref_clk) pick <= 1'b0;
    repeat (5) @(posedge ref_clk);
  endtask
  // hang guard, run needs well under a thousand cycles
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      complete_run;
    end
  end
  initial begin
    repeat (5) @(posedge ref_clk);
    #1 chk({tacho, ipulse, stall, busy, serr}, 5'h10);
    @(posedge ref_clk) reset_n <= 1'b1;
    foreach (rows[i]) begin
      zc(rows[i][4], rows[i][3:1]);
      chk({tacho, ipulse}, {rows[i][0], 1'b0});
    end
    chk(fall_cnt, 3);
    foreach (miss[i]) begin
      rise;
      starts(miss[i][7:4]);
      zc(1'b1, miss[i][2:0]);
      chk({tacho, ipulse}, 2'h0);
      zc(1'b0, 3'h4);
    end
    rise;
    starts(3);
    zc(1'b1, 3'h5);
    chk({tacho, ipulse}, 2'h1);
    zc(1'b0, 3'h6);
    chk(tacho, 0);
    repeat (8) @(posedge ref_clk);
    #1 chk(tacho, 1);
    @(posedge ref_clk) comm.emf_wrong <= 1'b1;
    starts(1);
    #1 chk(busy, 1);
    k = 0;
    while (stall !== 1'b1 && k < 40) begin
      @(posedge ref_clk);
      #1 k++;
    end
    chk({stall, k >= 20}, 2'h3);
    @(posedge ref_clk);
    #1 chk(busy, 0);
    starts(1);
    repeat (6) @(posedge ref_clk);
    comm.emf_wrong <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1 chk({busy, stall}, 2'h0);
    @(posedge ref_clk) comm.comm_state <= 3'h7;
    @(posedge ref_clk) comm.comm_state <= 3'h1;
    #1 chk(serr, 1);
    complete_run;
  end
endmodule

// file: dv/tipg_host_model.sv
// host counting tacho falls, plus the index pick-up
// assumes the bench pulses pick once per wanted sensor rise
`timescale 1ns/1ns
module tipg_host_model (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // tacho pin and pick-up request
  input wire logic combined_speed_out,
  input wire logic pick,
  // count and sensor
  output int fall_cnt,
  output logic index_sense_in
);
  logic last_ff = 1'b1;
  int hold_ff = 0;
  // falls only, as the host interrupt sees them
  always @(posedge ref_clk) begin
    last_ff <= combined_speed_out;
    if (!reset_n) fall_cnt <= 0;
    else if (last_ff && !combined_speed_out) fall_cnt <= fall_cnt + 1;
  end
  // sensor rises on request, otherwise rests grounded
  always @(posedge ref_clk) begin
    if (pick) hold_ff <= 4;
    else if (hold_ff > 0) hold_ff <= hold_ff - 1;
  end
  assign index_sense_in = hold_ff > 0;
endmodule

// file: dv/tipg_top_assertions.sv
// port checker for the tacho and index generator
// assumes the bench sets INDEX_CYC 8 and DELAY_CYC 3
`timescale 1ns/1ns
module tipg_chk #(
  parameter int INDEX_CYC = 8
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // commutation side
  input wire tipg_pkg::tipg_comm_t comm_in,
  // outputs watched
  input wire logic tacho_out,
  input wire logic combined_speed_out,
  input wire logic index_pulse,
  input wire logic stall_pulse,
  input wire logic timing_busy,
  input wire logic state_error
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // a high tacho always falls on a crossing
  a_tacho_fall: assert property (
    comm_in.zc_pulse && tacho_out |=> !tacho_out) else $error("no fall");
  a_tacho_hold: assert property (
    !comm_in.zc_pulse && tacho_out |=> tacho_out) else $error("stray fall");
  a_index_fell: assert property (
    index_pulse |-> $fell(tacho_out)) else $error("index off fall");
  // short low is exactly eight cycles with the bench figure
  a_index_low: assert property (
    index_pulse |-> !tacho_out [*8] ##1 tacho_out) else $error("low len");
  a_index_phase: assert property (
    index_pulse |-> $past(comm_in.zc_falling) &&
    $past(comm_in.comm_state) inside {3'h2, 3'h5}) else $error("phase");
  a_comb_same: assert property (
    combined_speed_out == tacho_out) else $error("combined differs");
  a_busy_start: assert property (
    comm_in.comm_start |=> timing_busy) else $error("no busy");
  a_stall_cause: assert property (
    stall_pulse |-> $past(comm_in.emf_wrong)) else $error("stall cause");
  a_wd_drop: assert property (
    comm_in.comm_start ##1 (!comm_in.comm_start && !comm_in.emf_wrong) [*8]
    |-> !timing_busy) else $error("busy stuck");
  a_state_flag: assert property (
    state_error == ($past(comm_in.comm_state) inside {3'h0, 3'h7}))
    else $error("state flag");
endmodule
bind tipg_top tipg_chk #(.INDEX_CYC(INDEX_CYC)) u_chk (
  .ref_clk(ref_clk), .reset_n(reset_n), .comm_in(comm_in),
  .tacho_out(tacho_out), .combined_speed_out(combined_speed_out),
  .index_pulse(index_pulse), .stall_pulse(stall_pulse),
  .timing_busy(timing_busy), .state_error(state_error));

// file: verilog/tipg_pkg.sv
// package for the tacho and index pulse generator
// assumes a single 250 MHz design clock
package tipg_pkg;
  // clock and timing
  localparam int CLK_MHZ = 250;
  localparam int INDEX_LOW_US = 18;
  localparam int INDEX_LOW_CYC = INDEX_LOW_US * CLK_MHZ;
  // watchdog figures, in microseconds and in cycles
  localparam int DELAY_STEP_US = 2;
  localparam int WDOG_US = 4000;
  localparam int DELAY_STEP_CYC = DELAY_STEP_US * CLK_MHZ;
  localparam int WDOG_CYC = WDOG_US * CLK_MHZ;
  // index window in commutation periods, scaled by two (1.5 .. 7.5)
  localparam int WIN_MIN_HALF = 3;
  localparam int WIN_MAX_HALF = 15;
  localparam int WIN_MIN_COMM = (WIN_MIN_HALF + 1) / 2;
  localparam int WIN_MAX_COMM = WIN_MAX_HALF / 2;
  // reset value and state count
  localparam logic TACHO_RST = 1'b1;
  localparam int NUM_STATES = 6;

  // commutation-side inputs, one bundle
  typedef struct packed {
    logic zc_pulse;
    logic zc_falling;
    logic [2:0] comm_state;
    logic emf_wrong;
    logic comm_start;
  } tipg_comm_t;

  typedef enum logic [1:0] {
    TIPG_WD_IDLE,
    TIPG_WD_DELAY,
    TIPG_WD_RUN
  } tipg_wd_state_t;
endpackage

// file: verilog/tipg_top.sv
// tacho output with once-per-revolution shortened index low phase
// assumes zero-crossing inputs come from commutation logic on ref_clk;
// the index sensor input is asynchronous and is synchronised here
`timescale 1ns/1ns
module tipg_top #(
  parameter int INDEX_CYC = tipg_pkg::INDEX_LOW_CYC,
  parameter int DELAY_CYC = tipg_pkg::DELAY_STEP_CYC,
  parameter int WDOG_CYC = tipg_pkg::WDOG_CYC,
  parameter int WIN_MIN = tipg_pkg::WIN_MIN_COMM,
  parameter int WIN_MAX = tipg_pkg::WIN_MAX_COMM
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // commutation logic
  input wire tipg_pkg::tipg_comm_t comm_in,
  // index pick-up, asynchronous
  input wire logic index_sense_in,
  // host side
  output logic tacho_out,
  output logic combined_speed_out,
  output logic index_pulse,
  // watchdog and illegal-state flag
  output logic stall_pulse,
  output logic timing_busy,
  output logic state_error
);
  localparam int IW = 16;
  localparam int WW = 4;

  initial begin
    if (INDEX_CYC < 1 || INDEX_CYC >= (1 << IW) || WIN_MIN < 1 ||
        WIN_MAX < WIN_MIN || WIN_MAX >= (1 << WW)) begin
      $error("tipg_top: bad parameters");
    end
  end

  // legal commutation state is 1..6
  function automatic logic state_ok(input logic [2:0] s);
    state_ok = (s >= 3'h1) && (s <= 3'(tipg_pkg::NUM_STATES));
  endfunction

  // third phase floats in states 2 and 5 only
  function automatic logic phase3_floats(input logic [2:0] s);
    phase3_floats = (s == 3'h2) || (s == 3'h5);
  endfunction

  logic sense_s1_ff;
  logic sense_s2_ff;
  logic sense_d_ff;
  logic armed_ff;
  logic [WW-1:0] age_ff;
  logic tacho_ff;
  logic short_ff;
  logic [IW-1:0] icnt_ff;
  logic index_ff;
  logic serr_ff;
  logic sense_rise;
  logic zc;
  logic idx_hit;
  logic age_ok;

  // two-stage synchroniser for the pick-up input
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      sense_s1_ff <= 1'b0;
      sense_s2_ff <= 1'b0;
      sense_d_ff <= 1'b0;
    end else begin
      sense_s1_ff <= index_sense_in;
      sense_s2_ff <= sense_s1_ff;
      sense_d_ff <= sense_s2_ff;
    end
  end

  assign sense_rise = sense_s2_ff & ~sense_d_ff;
  assign zc = comm_in.zc_pulse;
  assign age_ok = (age_ff >= WW'(WIN_MIN)) && (age_ff <= WW'(WIN_MAX));
  // a crossing sets the timing, the sensor only selects it
  assign idx_hit = zc & comm_in.zc_falling &
                   phase3_floats(comm_in.comm_state) &
                   armed_ff & age_ok;

  // arm on sensor edge, age in commutation periods
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      armed_ff <= 1'b0;
      age_ff <= '0;
    end else if (sense_rise) begin
      armed_ff <= 1'b1;
      age_ff <= '0;
    end else if (idx_hit) begin
      armed_ff <= 1'b0;
    end else if (armed_ff && comm_in.comm_start) begin
      // too old a sensor edge is dropped, not held over
      if (age_ff == WW'(WIN_MAX)) begin
        armed_ff <= 1'b0;
      end
      age_ff <= age_ff + 1'b1;
    end
  end

  // tacho toggles per crossing, index low cut short by counter
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      tacho_ff <= tipg_pkg::TACHO_RST;
      short_ff <= 1'b0;
      icnt_ff <= '0;
    end else if (short_ff) begin
      // crossings during the short low are ignored, the counter restores the level
      if (icnt_ff == IW'(INDEX_CYC - 1)) begin
        tacho_ff <= 1'b1;
        short_ff <= 1'b0;
        icnt_ff <= '0;
      end else begin
        icnt_ff <= icnt_ff + 1'b1;
      end
    end else if (zc) begin
      tacho_ff <= ~tacho_ff;
      if (tacho_ff && idx_hit) begin
        short_ff <= 1'b1;
        icnt_ff <= '0;
      end
    end
  end

  // index marker pulse, one cycle at the shortened fall
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      index_ff <= 1'b0;
    end else begin
      index_ff <= zc & tacho_ff & idx_hit & ~short_ff;
    end
  end

  // flag an illegal commutation state, 0 or 7
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      serr_ff <= 1'b0;
    end else begin
      serr_ff <= ~state_ok(comm_in.comm_state);
    end
  end

  tipg_watchdog #(
    .DELAY_CYC(DELAY_CYC),
    .WDOG_CYC(WDOG_CYC),
    .CW(32)
  ) u_wd (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .comm_start(comm_in.comm_start),
    .emf_wrong(comm_in.emf_wrong),
    .stall_pulse(stall_pulse),
    .timing_busy(timing_busy)
  );

  assign tacho_out = tacho_ff;
  assign combined_speed_out = tacho_ff;
  assign index_pulse = index_ff;
  assign state_error = serr_ff;
endmodule

// file: verilog/tipg_watchdog.sv
// commutation watchdog: delay step then guarded interval
// assumes start and polarity inputs are already on ref_clk
`timescale 1ns/1ns
module tipg_watchdog #(
  parameter int DELAY_CYC = tipg_pkg::DELAY_STEP_CYC,
  parameter int WDOG_CYC = tipg_pkg::WDOG_CYC,
  parameter int CW = 32
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // commutation side
  input wire logic comm_start,
  input wire logic emf_wrong,
  // result
  output logic stall_pulse,
  output logic timing_busy
);
  initial begin
    if (DELAY_CYC < 1 || WDOG_CYC < 1 || CW < 2) begin
      $error("tipg_watchdog: bad parameters");
    end
  end

  tipg_pkg::tipg_wd_state_t state_ff;
  logic [CW-1:0] cnt_ff;
  logic stall_ff;

  // fast delay step first, then slow watchdog ramp
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      state_ff <= tipg_pkg::TIPG_WD_IDLE;
      cnt_ff <= '0;
      stall_ff <= 1'b0;
    end else begin
      stall_ff <= 1'b0;
      if (comm_start) begin
        state_ff <= tipg_pkg::TIPG_WD_DELAY;
        cnt_ff <= '0;
      end else begin
        unique case (state_ff)
          tipg_pkg::TIPG_WD_IDLE: cnt_ff <= '0;
          tipg_pkg::TIPG_WD_DELAY: begin
            if (cnt_ff == CW'(DELAY_CYC - 1)) begin
              state_ff <= tipg_pkg::TIPG_WD_RUN;
              cnt_ff <= '0;
            end else begin
              cnt_ff <= cnt_ff + 1'b1;
            end
          end
          tipg_pkg::TIPG_WD_RUN: begin
            // correct polarity ends the step at once
            if (!emf_wrong) begin
              state_ff <= tipg_pkg::TIPG_WD_IDLE;
              cnt_ff <= '0;
            end else if (cnt_ff == CW'(WDOG_CYC - 1)) begin
              state_ff <= tipg_pkg::TIPG_WD_IDLE;
              cnt_ff <= '0;
              stall_ff <= 1'b1;
            end else begin
              cnt_ff <= cnt_ff + 1'b1;
            end
          end
          default: state_ff <= tipg_pkg::TIPG_WD_IDLE;
        endcase
      end
    end
  end

  assign stall_pulse = stall_ff;
  assign timing_busy = (state_ff != tipg_pkg::TIPG_WD_IDLE);
endmodule
